// ---- src/serial_ctrl_pkg.sv ----
// Purpose: Shared constants and carriers for the serial control/status/baud block
// Assumes: CPU I/O-space access with one-cycle read and write strobes
// Notes:   Register locations are indices on the block's local I/O address

package serial_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register locations within the block's I/O window
  localparam logic [2:0] ADDR_DATA = 3'h0;      // Data register
  localparam logic [2:0] ADDR_CSA = 3'h1;       // Control/status A
  localparam logic [2:0] ADDR_CSB = 3'h2;       // Control/status B
  localparam logic [2:0] ADDR_SHARED = 3'h3;    // Baud high / frame config
  localparam logic [2:0] ADDR_BAUDLO = 3'h4;    // Baud low

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_CSB = 8'h00;
  localparam logic [7:0] RST_FRAME = 8'h86;
  localparam logic [3:0] RST_BAUDHI = 4'h0;
  localparam logic [7:0] RST_BAUDLO = 8'h00;

  // Control/status A bit positions
  localparam int CSA_RXDONE = 7;
  localparam int CSA_TXDONE = 6;
  localparam int CSA_TXEMPTY = 5;
  localparam int CSA_FRAMEERR = 4;
  localparam int CSA_OVERRUN = 3;
  localparam int CSA_PARERR = 2;
  localparam int CSA_DOUBLE = 1;
  localparam int CSA_MPROC = 0;

  // Control/status B bit positions
  localparam int CSB_RXIE = 7;
  localparam int CSB_TXIE = 6;
  localparam int CSB_EMPTYIE = 5;
  localparam int CSB_RX_ENABLE = 4;
  localparam int CSB_TX_ENABLE = 3;
  localparam int CSB_SIZEMSB = 2;
  localparam int CSB_RXBIT8 = 1;
  localparam int CSB_TXBIT8 = 0;

  // Shared location select bit
  localparam int REGSEL_BIT = 7;

  // Baud divider oversampling ratios
  localparam logic [4:0] OVERSAMPLE_NORMAL = 5'h10;
  localparam logic [4:0] OVERSAMPLE_DOUBLE = 5'h08;

  // Character size codes
  localparam logic [2:0] SIZE_NINE = 3'h7;

  // Parity mode codes
  localparam logic [1:0] PARITY_OFF = 2'h0;
  localparam logic [1:0] PARITY_EVEN = 2'h2;
  localparam logic [1:0] PARITY_ODD = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Frame configuration register layout
  typedef struct packed {
    logic regSelect;
    logic syncSelect;
    logic [1:0] parityMode;
    logic stopSelect;
    logic [1:0] charSize;
    logic clkPolarity;
  } frame_cfg_t;

  // One received character with its error tags
  typedef struct packed {
    logic frameErr;
    logic parityErr;
    logic overrun;
    logic [8:0] data;
  } rx_entry_t;

  // Configuration exported to the shifters
  typedef struct packed {
    logic rxEnable;
    logic txPinOwned;
    logic syncMode;
    logic [4:0] oversample;
    logic [3:0] dataBits;
    logic [1:0] stopBits;
    logic parityOn;
    logic parityOdd;
    logic txDataOnRise;
    logic multiProc;
    logic [11:0] baudDivisor;
  } link_cfg_t;

endpackage

// ---- src/serial_ctrl.sv ----
// Purpose: Control, status and baud configuration of a serial transceiver
// Assumes: Shifters and sampling logic sit outside and use linkCfg
// Notes:   Receive buffer is the FIFO module inside this file
//
// Contract
// - Overrun on full buffer plus new start
// - Error flags follow the oldest unread character
// - Parity error only when checking was enabled
// - Double speed halves divider in async
// - Multiprocessor mode drops non-address frames
// - Interrupt needs enable, global flag, status
// - Rx enable owns pin; clear flushes buffer
// - Tx disable waits for empty path
// - Size field selects five to nine bits
// - Select bit one means frame config
// - Select bit zero means baud high
// - Sync select chooses async or sync
// - Parity mode off, even or odd
// - Stop select sets transmitter stop bits
// - Clock polarity picks data edges
// - Shared write steered by top bit
// - Back-to-back shared read returns config
// - Divisor is twelve bits high plus low
// - Baud low write reloads prescaler
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Parameterised FIFO with valid/ready on both sides
module serial_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Flush
  input wire logic flush,
  // Fill side
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // Drain side
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW:0] wrPtr_q;           // Write pointer with wrap bit
  logic [AW:0] rdPtr_q;           // Read pointer with wrap bit
  logic doWr;
  logic doRd;

  // Full when pointers differ only in wrap bit
  assign inReady = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
  assign outValid = (wrPtr_q != rdPtr_q);
  assign outData = mem[rdPtr_q[AW-1:0]];
  assign doWr = inValid && inReady && !flush;
  assign doRd = outValid && outReady && !flush;

  // Storage write, no reset needed on data
  always_ff @(posedge clock) begin
    if (doWr) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  // Pointer update
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else if (flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (doWr) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Top: register file and status logic
module serial_ctrl #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // CPU I/O access
  input wire logic [2:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWdata,
  output logic [7:0] ioRdata,
  input wire logic globalIrqEnable,
  input wire logic txDoneIrqAck,
  // Receive shifter side
  input wire logic [8:0] rxCharData,
  input wire logic rxCharValid,
  output logic rxCharReady,
  input wire logic rxCharFrameErr,
  input wire logic rxCharParityFail,
  input wire logic rxCharIsAddress,
  input wire logic rxStartDetect,
  // Transmit shifter side
  output logic [8:0] txCharData,
  output logic txCharValid,
  input wire logic txCharTake,
  input wire logic txShiftBusy,
  // Configuration and pin ownership
  output serial_ctrl_pkg::link_cfg_t linkCfg,
  output logic baudReload,
  // Interrupt requests
  output logic rxDoneIrq,
  output logic txDoneIrq,
  output logic txEmptyIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0] csb;                      // Control/status B
    serial_ctrl_pkg::frame_cfg_t frame;   // Frame configuration
    logic [3:0] baudHi;                   // Divisor upper nibble
    logic [7:0] baudLo;                   // Divisor low byte
    logic doubleSpeed;
    logic multiProc;
    logic txDone;
    logic txBufFull;
    logic [8:0] txBuf;
    logic txPinOwned;
    logic txValid;                        // Buffer offered to the shifter
    logic txPrevBusy;                     // Shifter busy last cycle
    logic pendOverrun;                    // Overrun tag for next stored char
    logic sharedReadPrev;                 // Shared location read last cycle
    logic [7:0] rdata;
    logic baudReload;
    logic [2:0] irq;
    serial_ctrl_pkg::link_cfg_t cfg;
  } state_t;

  state_t s_q;
  state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer: FIFO_DEPTH entries of the character FIFO
  localparam int EW = $bits(serial_ctrl_pkg::rx_entry_t);
  serial_ctrl_pkg::rx_entry_t inEntry;
  serial_ctrl_pkg::rx_entry_t headEntry;
  logic [EW-1:0] headBits;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic fifoPush;
  logic rxFlush;
  logic dropFrame;
  logic parityChecked;
  logic [EW-1:0] inBits;

  assign parityChecked = s_q.frame.parityMode[1];
  assign dropFrame = s_q.multiProc && !rxCharIsAddress;
  assign inEntry.frameErr = rxCharFrameErr;
  assign inEntry.parityErr = rxCharParityFail && parityChecked;
  assign inEntry.overrun = s_q.pendOverrun;
  assign inEntry.data = rxCharData;
  assign inBits = inEntry;
  assign rxFlush = !s_q.csb[serial_ctrl_pkg::CSB_RX_ENABLE];
  assign fifoPush = rxCharValid && !dropFrame;
  assign rxCharReady = fifoInReady || dropFrame || rxFlush;
  assign fifoPop = ioRead && (ioAddr == serial_ctrl_pkg::ADDR_DATA);
  assign headEntry = headBits;

  serial_fifo #(
    .WIDTH(EW),
    .DEPTH(FIFO_DEPTH)
  ) rxFifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .flush(rxFlush),
    .inData(inBits),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .outData(headBits),
    .outValid(fifoOutValid),
    .outReady(fifoPop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode of data bits from the size code
  function automatic logic [3:0] size_bits(input logic [2:0] code);
    case (code)
      3'h0: size_bits = 4'h5;
      3'h1: size_bits = 4'h6;
      3'h2: size_bits = 4'h7;
      3'h3: size_bits = 4'h8;
      3'h7: size_bits = 4'h9;
      default: size_bits = 4'h8;  // Reserved codes fall back to eight
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [2:0] sizeCode;
    logic sharedRd;
    logic txEmpty;
    sizeCode = 3'h0;
    sharedRd = 1'b0;
    txEmpty = 1'b0;
    s_d = s_q;
    s_d.baudReload = 1'b0;
    sharedRd = ioRead && (ioAddr == serial_ctrl_pkg::ADDR_SHARED);
    // Overrun: buffer full, char waiting, start seen
    if (!fifoInReady && rxCharValid && !dropFrame && rxStartDetect) begin
      s_d.pendOverrun = 1'b1;
    end else if (fifoPush && fifoInReady) begin
      s_d.pendOverrun = 1'b0;
    end
    if (rxFlush) begin
      s_d.pendOverrun = 1'b0;
    end
    // Transmit buffer handoff to shifter
    if (txCharTake) begin
      s_d.txBufFull = 1'b0;
    end
    // Done flag: set wins over clear
    if (txDoneIrqAck) begin
      s_d.txDone = 1'b0;
    end
    // Register writes
    if (ioWrite) begin
      case (ioAddr)
        serial_ctrl_pkg::ADDR_DATA: begin
          if (!s_q.txBufFull) begin  // Ignored while buffer busy
            s_d.txBuf = {s_q.csb[serial_ctrl_pkg::CSB_TXBIT8], ioWdata};
            s_d.txBufFull = 1'b1;
          end
        end
        serial_ctrl_pkg::ADDR_CSA: begin
          // Error bits are read-only here; software writes them zero
          if (ioWdata[serial_ctrl_pkg::CSA_TXDONE]) begin
            s_d.txDone = 1'b0;
          end
          s_d.doubleSpeed = ioWdata[serial_ctrl_pkg::CSA_DOUBLE];
          s_d.multiProc = ioWdata[serial_ctrl_pkg::CSA_MPROC];
        end
        serial_ctrl_pkg::ADDR_CSB: begin
          s_d.csb = {ioWdata[7:2], 1'b0, ioWdata[0]};
        end
        serial_ctrl_pkg::ADDR_SHARED: begin
          if (ioWdata[serial_ctrl_pkg::REGSEL_BIT]) begin
            s_d.frame = ioWdata;
            s_d.frame.regSelect = 1'b1;
          end else begin
            s_d.baudHi = ioWdata[3:0];
          end
        end
        serial_ctrl_pkg::ADDR_BAUDLO: begin
          s_d.baudLo = ioWdata;
          s_d.baudReload = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Shifter just went idle with nothing pending; set wins over any clear
    if (s_q.txPrevBusy && !txShiftBusy && !s_q.txBufFull && s_q.txPinOwned) begin
      s_d.txDone = 1'b1;
    end
    s_d.txPrevBusy = txShiftBusy;
    // Pin ownership: release only when path empty
    txEmpty = !s_q.txBufFull && !txShiftBusy;
    if (s_q.csb[serial_ctrl_pkg::CSB_TX_ENABLE]) begin
      s_d.txPinOwned = 1'b1;
    end else if (txEmpty) begin
      s_d.txPinOwned = 1'b0;
    end
    s_d.txValid = s_d.txBufFull && s_d.txPinOwned;
    // Read data: shared location timed sequence
    s_d.sharedReadPrev = sharedRd;
    s_d.rdata = 8'h00;
    if (ioRead) begin
      case (ioAddr)
        serial_ctrl_pkg::ADDR_DATA: s_d.rdata = fifoOutValid ? headEntry.data[7:0] : 8'h00;
        serial_ctrl_pkg::ADDR_CSA: begin
          s_d.rdata = {fifoOutValid, s_q.txDone, !s_q.txBufFull,
                       fifoOutValid && headEntry.frameErr,
                       fifoOutValid && headEntry.overrun,
                       fifoOutValid && headEntry.parityErr,
                       s_q.doubleSpeed, s_q.multiProc};
        end
        serial_ctrl_pkg::ADDR_CSB: begin
          s_d.rdata = s_q.csb;
          s_d.rdata[serial_ctrl_pkg::CSB_RXBIT8] = fifoOutValid && headEntry.data[8];
        end
        serial_ctrl_pkg::ADDR_SHARED: begin
          if (s_q.sharedReadPrev) begin
            s_d.rdata = s_q.frame;
            s_d.rdata[serial_ctrl_pkg::REGSEL_BIT] = 1'b1;
          end else begin
            s_d.rdata = {4'h0, s_q.baudHi};
          end
        end
        serial_ctrl_pkg::ADDR_BAUDLO: s_d.rdata = s_q.baudLo;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Interrupt requests gated by enable and global flag
    s_d.irq[0] = globalIrqEnable && s_q.csb[serial_ctrl_pkg::CSB_RXIE] && fifoOutValid;
    s_d.irq[1] = globalIrqEnable && s_q.csb[serial_ctrl_pkg::CSB_TXIE] && s_q.txDone;
    s_d.irq[2] = globalIrqEnable && s_q.csb[serial_ctrl_pkg::CSB_EMPTYIE] && !s_q.txBufFull;
    // Configuration export from next state, so the divisor lands with the reload pulse
    sizeCode = {s_d.csb[serial_ctrl_pkg::CSB_SIZEMSB], s_d.frame.charSize};
    s_d.cfg.rxEnable = s_d.csb[serial_ctrl_pkg::CSB_RX_ENABLE];
    s_d.cfg.txPinOwned = s_d.txPinOwned;
    s_d.cfg.syncMode = s_d.frame.syncSelect;
    s_d.cfg.oversample = (s_d.doubleSpeed && !s_d.frame.syncSelect) ?
                         serial_ctrl_pkg::OVERSAMPLE_DOUBLE : serial_ctrl_pkg::OVERSAMPLE_NORMAL;
    s_d.cfg.dataBits = size_bits(sizeCode);
    s_d.cfg.stopBits = s_d.frame.stopSelect ? 2'h2 : 2'h1;
    s_d.cfg.parityOn = (s_d.frame.parityMode == serial_ctrl_pkg::PARITY_EVEN) ||
                       (s_d.frame.parityMode == serial_ctrl_pkg::PARITY_ODD);
    s_d.cfg.parityOdd = (s_d.frame.parityMode == serial_ctrl_pkg::PARITY_ODD);
    s_d.cfg.txDataOnRise = !s_d.frame.clkPolarity;
    s_d.cfg.multiProc = s_d.multiProc;
    s_d.cfg.baudDivisor = {s_d.baudHi, s_d.baudLo};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register stage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.csb <= serial_ctrl_pkg::RST_CSB;
      s_q.frame <= serial_ctrl_pkg::RST_FRAME;
      s_q.baudHi <= serial_ctrl_pkg::RST_BAUDHI;
      s_q.baudLo <= serial_ctrl_pkg::RST_BAUDLO;
      s_q.cfg.oversample <= serial_ctrl_pkg::OVERSAMPLE_NORMAL;
      s_q.cfg.dataBits <= 4'h8;
      s_q.cfg.stopBits <= 2'h1;
      s_q.cfg.txDataOnRise <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign ioRdata = s_q.rdata;
  assign linkCfg = s_q.cfg;
  assign baudReload = s_q.baudReload;
  assign rxDoneIrq = s_q.irq[0];
  assign txDoneIrq = s_q.irq[1];
  assign txEmptyIrq = s_q.irq[2];
  assign txCharData = s_q.txBuf;
  assign txCharValid = s_q.txValid;
endmodule

// ---- tb/serial_ctrl_checker.sv ----
// Purpose: Port-level assertions for the serial control block
// Assumes: One clock domain, async active-high reset
// Notes:   Bound to serial_ctrl at the foot of this file
`timescale 1ns/1ps
module serial_ctrl_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // CPU access
  input wire logic [2:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWdata,
  input wire logic [7:0] ioRdata,
  input wire logic globalIrqEnable,
  // Shifter side
  input wire logic rxCharValid,
  input wire logic rxCharReady,
  input wire logic rxCharIsAddress,
  input wire logic txShiftBusy,
  // Watched outputs
  input wire serial_ctrl_pkg::link_cfg_t linkCfg,
  input wire logic baudReload,
  input wire logic rxDoneIrq,
  input wire logic txDoneIrq,
  input wire logic txEmptyIrq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Decoded accesses to the shared location
  wire logic shRd = ioRead && ioAddr == serial_ctrl_pkg::ADDR_SHARED;
  wire logic shWr = ioWrite && ioAddr == serial_ctrl_pkg::ADDR_SHARED;
  wire logic cfgWr = shWr && ioWdata[7];

  ////////////////////////////////////////////////////////////////////////////
  AST_BAUD_RELOAD: assert property (ioWrite && ioAddr == serial_ctrl_pkg::ADDR_BAUDLO |=>
    baudReload && linkCfg.baudDivisor[7:0] == $past(ioWdata)) else $error("baud low write not applied");
  AST_BAUD_HIGH: assert property (shWr && !ioWdata[7] |=>
    linkCfg.baudDivisor[11:8] == $past(ioWdata[3:0])) else $error("baud high write not applied");
  AST_CFG_WRITE: assert property (cfgWr |=> linkCfg.syncMode == $past(ioWdata[6]) &&
    linkCfg.stopBits == ($past(ioWdata[3]) ? 2'h2 : 2'h1) && linkCfg.parityOn == $past(ioWdata[5]))
    else $error("frame config write not applied");
  AST_POLARITY: assert property (cfgWr && ioWdata[6] |=>
    linkCfg.txDataOnRise == !$past(ioWdata[0])) else $error("clock polarity wrong");
  AST_DOUBLE: assert property (ioWrite && ioAddr == serial_ctrl_pkg::ADDR_CSA && !linkCfg.syncMode |=>
    linkCfg.oversample == ($past(ioWdata[1]) ? serial_ctrl_pkg::OVERSAMPLE_DOUBLE :
    serial_ctrl_pkg::OVERSAMPLE_NORMAL)) else $error("oversample ratio wrong");
  AST_SHARED_FIRST: assert property (shRd && !$past(shRd) |=> ioRdata[7:4] == 4'h0)
    else $error("single shared read not baud high");
  AST_SHARED_SECOND: assert property (shRd ##1 shRd |=> ioRdata[7])
    else $error("second shared read not frame config");
  AST_RX_PIN: assert property (ioWrite && ioAddr == serial_ctrl_pkg::ADDR_CSB |=>
    linkCfg.rxEnable == $past(ioWdata[4])) else $error("receiver enable not applied");
  AST_MPROC_DROP: assert property (rxCharValid && !rxCharIsAddress && linkCfg.multiProc |-> rxCharReady)
    else $error("data frame not dropped");
  AST_TX_HOLD: assert property (linkCfg.txPinOwned && txShiftBusy |=> linkCfg.txPinOwned)
    else $error("transmit pin released while busy");
  AST_IRQ_GATE: assert property (!globalIrqEnable [*2] |-> !rxDoneIrq && !txDoneIrq && !txEmptyIrq)
    else $error("interrupt without global enable");

  // Main scenarios reached
  cover property (shRd ##1 shRd);
  cover property (rxCharValid && !rxCharReady);
  cover property (linkCfg.txPinOwned && txShiftBusy);
endmodule

bind serial_ctrl serial_ctrl_checker i_serial_ctrl_checker (.clock(clock), .sys_rst(sys_rst),
  .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata),
  .globalIrqEnable(globalIrqEnable), .rxCharValid(rxCharValid), .rxCharReady(rxCharReady),
  .rxCharIsAddress(rxCharIsAddress), .txShiftBusy(txShiftBusy), .linkCfg(linkCfg),
  .baudReload(baudReload), .rxDoneIrq(rxDoneIrq), .txDoneIrq(txDoneIrq), .txEmptyIrq(txEmptyIrq));

// ---- tb/serial_shifter_model.sv ----
// Purpose: Behavioural receive and transmit shifters facing the block
// Assumes: Bench commands arrive as one-cycle pulses
// Notes:   Shift time comes from shiftCycles; the bench holds it at 40 cycles, so only slow shifting occurs
`timescale 1ns/1ps
module serial_shifter_model (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Bench commands
  input wire logic sendReq,
  input wire logic [8:0] sendData,
  input wire logic sendPar,
  input wire logic sendAddr,
  input wire logic startReq,
  input wire logic [7:0] shiftCycles,
  // Receive side
  output logic [8:0] rxCharData,
  output logic rxCharValid,
  input wire logic rxCharReady,
  output logic rxCharFrameErr,
  output logic rxCharParityFail,
  output logic rxCharIsAddress,
  output logic rxStartDetect,
  // Transmit side
  input wire logic [8:0] txCharData,
  input wire logic txCharValid,
  output logic txCharTake,
  output logic txShiftBusy,
  output logic [8:0] takenData
);
  logic [7:0] busyCnt; // Remaining shift cycles

  // Frame errors are not modelled
  assign rxCharFrameErr = 1'b0;
  assign txShiftBusy = busyCnt != 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Offer held until taken; afterwards the lines show inverted data
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      {rxCharData, rxCharValid, rxCharParityFail, rxCharIsAddress, rxStartDetect} <= '0;
      {txCharTake, busyCnt, takenData} <= '0;
    end else begin
      rxStartDetect <= startReq;
      txCharTake <= 1'b0;
      if (rxCharValid && rxCharReady) begin
        rxCharValid <= 1'b0;
        rxCharData <= ~rxCharData;
      end else if (sendReq && !rxCharValid) begin
        rxCharValid <= 1'b1;
        rxCharData <= sendData;
        rxCharParityFail <= sendPar;
        rxCharIsAddress <= sendAddr;
      end
      // Take the buffer only when the shift register is free
      if (busyCnt != 8'h00) begin
        busyCnt <= busyCnt - 8'h01;
      end else if (txCharValid && !txCharTake) begin
        txCharTake <= 1'b1;
        takenData <= txCharData;
        busyCnt <= shiftCycles;
      end
    end
  end
endmodule

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for serial_ctrl
// Assumes: Receive buffer shortened to four entries
// Notes:   Register access through one-cycle strobes
`timescale 1ns/1ps
module tb;
  localparam logic [2:0] LD = serial_ctrl_pkg::ADDR_DATA;
  localparam logic [2:0] LA = serial_ctrl_pkg::ADDR_CSA;
  localparam logic [2:0] LB = serial_ctrl_pkg::ADDR_CSB;
  localparam logic [2:0] LS = serial_ctrl_pkg::ADDR_SHARED;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] ioAddr = 3'h0;
  logic ioWrite = 1'b0;
  logic ioRead = 1'b0;
  logic [7:0] ioWdata = 8'h00;
  logic [7:0] ioRdata;
  logic gie = 1'b0;
  logic txDoneIrqAck = 1'b0;
  logic sendReq = 1'b0;
  logic [8:0] sendData = 9'h000;
  logic sendPar = 1'b0;
  logic sendAddr = 1'b0;
  logic startReq = 1'b0;
  logic [7:0] shiftCycles = 8'h28;
  logic [8:0] rxD, txD, takenData;
  logic rxV, rxR, rxFe, rxPf, rxIa, rxSd, txV, take, busy, reload, rxIrq, txIrq, emIrq;
  serial_ctrl_pkg::link_cfg_t cfg;
  int failCount = 0;
  int nCompared = 0;

  always #2.5 clock = ~clock;

  serial_ctrl #(.FIFO_DEPTH(4)) i_serial_ctrl (.clock(clock), .sys_rst(sys_rst), .ioAddr(ioAddr),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata), .globalIrqEnable(gie),
    .txDoneIrqAck(txDoneIrqAck), .rxCharData(rxD), .rxCharValid(rxV), .rxCharReady(rxR),
    .rxCharFrameErr(rxFe), .rxCharParityFail(rxPf), .rxCharIsAddress(rxIa), .rxStartDetect(rxSd),
    .txCharData(txD), .txCharValid(txV), .txCharTake(take), .txShiftBusy(busy), .linkCfg(cfg),
    .baudReload(reload), .rxDoneIrq(rxIrq), .txDoneIrq(txIrq), .txEmptyIrq(emIrq));
  serial_shifter_model i_serial_shifter_model (.clock(clock), .sys_rst(sys_rst), .sendReq(sendReq),
    .sendData(sendData), .sendPar(sendPar), .sendAddr(sendAddr), .startReq(startReq),
    .shiftCycles(shiftCycles), .rxCharData(rxD), .rxCharValid(rxV), .rxCharReady(rxR),
    .rxCharFrameErr(rxFe), .rxCharParityFail(rxPf), .rxCharIsAddress(rxIa), .rxStartDetect(rxSd),
    .txCharData(txD), .txCharValid(txV), .txCharTake(take), .txShiftBusy(busy), .takenData(takenData));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Write strobe held for exactly one edge
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    ioAddr <= a;
    ioWdata <= d;
    ioWrite <= 1'b1;
    @(posedge clock);
    ioWrite <= 1'b0;
  endtask
  // Read data is registered, so it is taken one cycle after the strobe
  task rd(input logic [2:0] a, input logic [15:0] exp, input string what);
    @(posedge clock);
    ioAddr <= a;
    ioRead <= 1'b1;
    @(posedge clock);
    ioRead <= 1'b0;
    #1 chk(what, ioRdata, exp);
  endtask
  // Two shared reads back to back
  task rdPair(input logic [7:0] e0, input logic [7:0] e1);
    @(posedge clock);
    ioAddr <= LS;
    ioRead <= 1'b1;
    @(posedge clock);
    #1 chk("sharedFirst", ioRdata, e0);
    @(posedge clock);
    ioRead <= 1'b0;
    #1 chk("sharedSecond", ioRdata, e1);
  endtask
  // Offer one character; the model holds it until the block takes it
  task send(input logic [8:0] d, input logic par);
    @(posedge clock);
    sendReq <= 1'b1;
    sendData <= d;
    sendPar <= par;
    @(posedge clock);
    sendReq <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task conclude;
    $display("Compared %0d, failed %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    failCount++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd(LB, 8'h00, "csbReset");
    rd(LA, 8'h20, "csaReset");
    rdPair(8'h00, 8'h86);
    wr(LS, 8'h0a);
    wr(serial_ctrl_pkg::ADDR_BAUDLO, 8'h5c);
    wr(LS, 8'hce);
    rdPair(8'h0a, 8'hce);
    chk("divisor", cfg.baudDivisor, 12'ha5c);
    chk("dataOnRise", cfg.txDataOnRise, 1'b1);
    chk("stopBits", cfg.stopBits, 2'h2);
    chk("syncMode", cfg.syncMode, 1'b1);
    wr(LS, 8'h86);
    wr(LA, 8'h02);
    @(posedge clock);
    chk("oversample", cfg.oversample, 5'h08);
    wr(LA, 8'h00);
    $display("Test registers done");
    // Every size code, reserved ones included
    for (int c = 0; c < 8; c++) begin
      wr(LB, {5'h00, c[2], 2'h0});
      wr(LS, {5'h10, c[1:0], 1'b0});
      @(posedge clock);
      chk("dataBits", cfg.dataBits, c < 4 ? c + 5 : c == 7 ? 9 : 8);
    end
    $display("Test sizes done");
    // Nine-bit frames, parity off: failed parity must not show
    wr(LB, 8'h14);
    send(9'h0a5, 1'b1);
    rd(LA, 8'ha0, "parityOff");
    rd(LD, 8'ha5, "data");
    wr(LA, 8'h01);
    send(9'h033, 1'b0);
    sendAddr <= 1'b1;
    send(9'h1c4, 1'b0);
    sendAddr <= 1'b0;
    rd(LB, 8'h16, "rxBit8");
    rd(LD, 8'hc4, "addrData");
    rd(LA, 8'h21, "mprocCsa");
    wr(LA, 8'h00);
    $display("Test multiproc done");
    // Fill the buffer, stall one more, then a new start bit; odd parity checked
    wr(LS, 8'hb6);
    wr(LB, 8'h10);
    chk("parityOdd", cfg.parityOdd, 1'b1);
    for (int i = 0; i < 5; i++) send(9'h040 + i, i == 1);
    @(posedge clock);
    startReq <= 1'b1;
    @(posedge clock);
    startReq <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(LA, 8'ha0 | (i == 1 ? 8'h04 : 8'h00) | (i == 4 ? 8'h08 : 8'h00), "errFlags");
      rd(LD, 8'h40 + i, "fifoData");
    end
    send(9'h077, 1'b0);
    wr(LB, 8'h00);
    rd(LA, 8'h20, "flushed");
    $display("Test overrun done");
    // Interrupt gating by enable and global flag
    wr(LB, 8'h90);
    send(9'h011, 1'b0);
    chk("rxIrqMasked", rxIrq, 1'b0);
    gie <= 1'b1;
    repeat (4) @(posedge clock);
    chk("rxIrq", rxIrq, 1'b1);
    rd(LD, 8'h11, "irqData");
    repeat (3) @(posedge clock);
    chk("rxIrqGone", rxIrq, 1'b0);
    chk("emptyIrqOff", emIrq, 1'b0);
    wr(LB, 8'h20);
    repeat (3) @(posedge clock);
    chk("emptyIrq", emIrq, 1'b1);
    $display("Test interrupts done");
    // Deferred transmitter disable while the shifter is slow
    wr(LB, 8'h49);
    wr(LD, 8'h5a);
    wr(LB, 8'h41);
    repeat (5) @(posedge clock);
    chk("pinHeld", cfg.txPinOwned, 1'b1);
    repeat (60) @(posedge clock);
    chk("pinReleased", cfg.txPinOwned, 1'b0);
    chk("txChar", takenData, 9'h15a);
    chk("txIrq", txIrq, 1'b1);
    @(posedge clock);
    txDoneIrqAck <= 1'b1;
    @(posedge clock);
    txDoneIrqAck <= 1'b0;
    repeat (3) @(posedge clock);
    chk("txIrqAck", txIrq, 1'b0);
    $display("Test transmit done");
    conclude();
  end
endmodule
